// File: iifd_pkg.sv
// constants, opcode map and carrier types of the image instruction decoder
package iifd_pkg;

	// ==========================================================
	// field widths
	localparam int OP_W   = 7;
	localparam int VREG_W = 8;
	localparam int SEL_W  = 5;
	localparam int SREG_W = 7;
	localparam int MASK_W = 4;
	localparam int NUMFMT_W = 4;
	localparam int CNT_W  = 4;

	// ==========================================================
	// scalar group alignment and spans
	localparam logic [1:0]       SEL_LOW_ZERO  = 2'h0;
	localparam logic [CNT_W-1:0] SAMPLER_REGS  = 4'h4;
	localparam logic [CNT_W-1:0] RSRC_NARROW   = 4'h4;
	localparam logic [CNT_W-1:0] RSRC_WIDE     = 4'h8;

	// ==========================================================
	// opcode map of the non-sampler ops
	localparam logic [OP_W-1:0] OP_LOAD         = 7'h00;
	localparam logic [OP_W-1:0] OP_LOAD_MIP     = 7'h01;
	localparam logic [OP_W-1:0] OP_LOAD_PCK     = 7'h02;
	localparam logic [OP_W-1:0] OP_LOAD_MIP_PCK = 7'h03;
	localparam logic [OP_W-1:0] OP_STORE        = 7'h08;
	localparam logic [OP_W-1:0] OP_STORE_MIP    = 7'h09;
	localparam logic [OP_W-1:0] OP_RESINFO      = 7'h0e;
	localparam logic [OP_W-1:0] OP_ATOMIC_LO    = 7'h10;
	localparam logic [OP_W-1:0] OP_ATOMIC_HI    = 7'h1f;

	// sampler ops: flag bits plus a level-of-detail mode field
	localparam int SMP_BIT  = 6;
	localparam int GATH_BIT = 5;
	localparam int CMP_BIT  = 4;
	localparam int OFS_BIT  = 3;
	localparam logic [2:0] LODM_PLAIN   = 3'h0;
	localparam logic [2:0] LODM_EXPL    = 3'h1;
	localparam logic [2:0] LODM_BIAS    = 3'h2;
	localparam logic [2:0] LODM_ZERO    = 3'h3;
	localparam logic [2:0] LODM_DERIV   = 3'h4;
	localparam logic [2:0] LODM_CDERIV  = 3'h5;
	localparam logic [2:0] LODM_CLAMP   = 3'h6;
	localparam logic [2:0] LODM_SPECIAL = 3'h7;

	// ==========================================================
	// address layout figures
	localparam logic [CNT_W-1:0] FACE_MUL_UINT  = 4'h6;
	localparam logic [CNT_W-1:0] FACE_MUL_FLOAT = 4'h8;
	localparam logic [CNT_W-1:0] OFFSET_REGS    = 4'h1;
	localparam logic [CNT_W-1:0] BIAS_REGS      = 4'h1;
	localparam logic [CNT_W-1:0] CMP_REGS       = 4'h1;
	localparam logic [CNT_W-1:0] DERIV_1D       = 4'h2;
	localparam logic [CNT_W-1:0] DERIV_2D       = 4'h4;
	localparam logic [CNT_W-1:0] DERIV_3D       = 4'h6;

	typedef enum logic [3:0] {
		DIM_1D, DIM_1D_ARRAY, DIM_2D, DIM_2D_MSAA, DIM_2D_ARRAY,
		DIM_2D_ARRAY_MSAA, DIM_3D, DIM_CUBE, DIM_2D_INTERLACED
	} iifd_dim_e;

	typedef struct packed {
		logic [OP_W-1:0]   opcodeField;
		logic [VREG_W-1:0] addrRegBase;
		logic [VREG_W-1:0] dataRegBase;
		logic [SEL_W-1:0]  samplerSelector;
		logic [SEL_W-1:0]  resourceSelector;
		logic              unnormalizedCoordBit;
		logic              arrayDeclaredBit;
		logic [MASK_W-1:0] componentMask;
		logic              coherentBit;
		logic              systemCoherentBit;
		logic              texelFailBit;
		logic              lodWarningBit;
		logic              halfWidthAddressBit;
		logic              halfWidthDataBit;
		logic [NUMFMT_W-1:0] numberFormatField;
		iifd_dim_e         dim;
	} iifd_instr_s;

	typedef struct packed {
		logic [SREG_W-1:0]          samplerReg;
		logic [SREG_W-1:0]          resourceReg;
		logic [CNT_W-1:0]           resourceSpan;
		logic                       hasSampler;
		logic                       isLoad;
		logic                       isStore;
		logic                       isAtomic;
		logic                       unnormalized;
		logic                       floatAddr;
		logic [CNT_W-1:0]           faceMul;
		logic                       explicitLod;
		logic                       levelZero;
		logic                       lodClamp;
		logic                       hasOffset;
		logic                       hasBias;
		logic                       hasCompare;
		logic [VREG_W-1:0]          offsetReg;
		logic [VREG_W-1:0]          biasReg;
		logic [VREG_W-1:0]          compareReg;
		logic [VREG_W-1:0]          derivReg;
		logic [CNT_W-1:0]           derivCount;
		logic [VREG_W-1:0]          bodyReg;
		logic [CNT_W-1:0]           bodyCount;
		logic [CNT_W-1:0]           addrRegCount;
		logic                       halfAddr;
		logic                       halfData;
		logic [NUMFMT_W-1:0]        numberFormat;
		logic [MASK_W-1:0]          compEnable;
		logic [MASK_W*VREG_W-1:0]   compReg;
		logic [MASK_W-1:0]          compHigh;
		logic [CNT_W-1:0]           dataRegCount;
		logic                       bypassL1;
		logic                       writeThrough;
		logic                       persistL1;
		logic                       returnPrior;
		logic                       missL2;
		logic                       nackAllowed;
		logic [VREG_W-1:0]          nackReg;
		logic                       detailClampedAllowed;
		logic                       illegal;
	} iifd_req_s;

endpackage

// File: iifd_decoder.sv
// image instruction field decoder and address-operand layout
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RQ1] selectors gain two zero low bits; sampler spans four, resource four or eight
// [RQ2] seven-bit opcode, eight-bit address and data register bases
// [RQ3] unnormalized bit forces unnormalized coords; required on stores and atomics
// [RQ4] array-declared bit means an array index operand is present
// [RQ5] read mask picks red, green, blue, alpha into consecutive data registers
// [RQ6] write mask components take consecutive registers; others written as zero
// [RQ7] half-data writes use the mask only as a count of half words
// [RQ8] coherence bit: reads skip first level, writes stop persisting, atomics return
// [RQ9] system-coherent bit forces a second-level texture cache miss
// [RQ10] texel-fail bit allows a nack written after all data registers
// [RQ11] lod-warning bit allows a detail-clamped indication on fetches
// [RQ12] half-address packs two coordinates per register; offsets and compare stay
// [RQ13] half-data converts loads to 16 bits and widens stores to 32
// [RQ14] half-data only on sample, gather, load, load-mip, store, store-mip; the code also flags it illegal on gathers with lod mode LODM_SPECIAL
// [RQ15] no sampler: uint coords, face times six; sampler: float, times eight
// [RQ16] offset, bias, compare and gradients add address registers
// [RQ17] explicit-lod uses supplied level; level-zero forces mip zero
// [RQ18] bias adds one operand; clamp supplies a level ceiling
// [RQ19] derivatives supply two, four or six slopes by dimension
// [RQ20] offset takes one packed register; compare adds one value
// [RQ21] opcode groups for sample and gather layouts
// [RQ22] order offset, bias, compare, derivatives, body of count plus one
// [RQ23] body x, y, slice or z or face, then trailing mip, lod or clamp
// [RQ24] forbidden combinations raise the illegal flag
module iifd_decoder (
	input  wire logic                 ref_clk,
	input  wire logic                 rstn,
	input  wire logic                 instValid,
	input  wire iifd_pkg::iifd_instr_s instr,
	output var  logic                 reqValid_ff,
	output var  iifd_pkg::iifd_req_s  req_ff
);

	// ==========================================================
	// opcode classification
	logic                        isSmp;
	logic                        isGather;
	logic [2:0]                  lodMode;
	logic                        isLd;
	logic                        isSt;
	logic                        isAt;
	logic                        isMipOp;
	logic                        isResinfo;
	logic                        halfOk;
	logic                        dimArray;
	logic                        hasOfs;
	logic                        hasBias;
	logic                        hasCmp;
	logic                        hasDeriv;
	logic                        hasTrail;
	logic [iifd_pkg::CNT_W-1:0]  coordCnt;
	logic [iifd_pkg::CNT_W-1:0]  bodyCnt;
	logic [iifd_pkg::CNT_W-1:0]  derivCnt;
	logic [iifd_pkg::CNT_W-1:0]  bodyRegs;
	logic [iifd_pkg::CNT_W-1:0]  derivRegs;
	logic [iifd_pkg::CNT_W-1:0]  maskCnt;
	logic [iifd_pkg::CNT_W-1:0]  dataRegs;
	logic [iifd_pkg::VREG_W-1:0] pOfs;
	logic [iifd_pkg::VREG_W-1:0] pBias;
	logic [iifd_pkg::VREG_W-1:0] pCmp;
	logic [iifd_pkg::VREG_W-1:0] pDeriv;
	logic [iifd_pkg::VREG_W-1:0] pBody;
	logic [iifd_pkg::MASK_W-1:0] compEn;
	logic [iifd_pkg::MASK_W*iifd_pkg::VREG_W-1:0] compReg;
	logic [iifd_pkg::MASK_W-1:0] compHigh;
	iifd_pkg::iifd_req_s         nxt_req;

	function automatic logic [iifd_pkg::CNT_W-1:0] popCount(
		input logic [iifd_pkg::MASK_W-1:0] m
	);
		logic [iifd_pkg::CNT_W-1:0] c;
		c = '0;
		for (int k = 0; k < iifd_pkg::MASK_W; k++) begin
			c = c + {3'h0, m[k]};
		end
		return c;
	endfunction

	// half-width packing: two per register, rounded up
	function automatic logic [iifd_pkg::CNT_W-1:0] halfRegs(
		input logic [iifd_pkg::CNT_W-1:0] n,
		input logic                       half
	);
		logic [iifd_pkg::CNT_W-1:0] r;
		r = half ? ((n + 4'h1) >> 1) : n;
		return r;
	endfunction

	always_comb begin
		isSmp     = instr.opcodeField[iifd_pkg::SMP_BIT]; // RQ2
		isGather  = isSmp & instr.opcodeField[iifd_pkg::GATH_BIT]; // RQ21
		lodMode   = isSmp ? instr.opcodeField[2:0] : iifd_pkg::LODM_PLAIN;
		isSt      = (instr.opcodeField == iifd_pkg::OP_STORE) |
			(instr.opcodeField == iifd_pkg::OP_STORE_MIP);
		isAt      = (instr.opcodeField >= iifd_pkg::OP_ATOMIC_LO) &
			(instr.opcodeField <= iifd_pkg::OP_ATOMIC_HI);
		isLd      = ~isSt & ~isAt;
		isMipOp   = (instr.opcodeField == iifd_pkg::OP_LOAD_MIP) |
			(instr.opcodeField == iifd_pkg::OP_LOAD_MIP_PCK) |
			(instr.opcodeField == iifd_pkg::OP_STORE_MIP);
		isResinfo = instr.opcodeField == iifd_pkg::OP_RESINFO;
		halfOk    = (isSmp & ~(isGather & (lodMode == iifd_pkg::LODM_SPECIAL))) |
			(instr.opcodeField == iifd_pkg::OP_LOAD) |
			(instr.opcodeField == iifd_pkg::OP_LOAD_MIP) | isSt; // RQ14
		hasOfs    = isSmp & instr.opcodeField[iifd_pkg::OFS_BIT]; // RQ16 RQ20
		hasBias   = lodMode == iifd_pkg::LODM_BIAS; // RQ18
		hasCmp    = isSmp & instr.opcodeField[iifd_pkg::CMP_BIT]; // RQ20
		hasDeriv  = (lodMode == iifd_pkg::LODM_DERIV) |
			(lodMode == iifd_pkg::LODM_CDERIV); // RQ19
		hasTrail  = isMipOp | (lodMode == iifd_pkg::LODM_EXPL) |
			(lodMode == iifd_pkg::LODM_CLAMP); // RQ23
	end

	// coordinate components per dimension, x first
	always_comb begin
		unique case (instr.dim) // RQ23
			iifd_pkg::DIM_1D: begin
				coordCnt = 4'h1;
				derivCnt = iifd_pkg::DERIV_1D;
				dimArray = 1'b0;
			end
			iifd_pkg::DIM_1D_ARRAY: begin
				coordCnt = 4'h2;
				derivCnt = iifd_pkg::DERIV_1D;
				dimArray = 1'b1;
			end
			iifd_pkg::DIM_2D: begin
				coordCnt = 4'h2;
				derivCnt = iifd_pkg::DERIV_2D;
				dimArray = 1'b0;
			end
			iifd_pkg::DIM_2D_ARRAY: begin
				coordCnt = 4'h3;
				derivCnt = iifd_pkg::DERIV_2D;
				dimArray = 1'b1;
			end
			iifd_pkg::DIM_2D_ARRAY_MSAA: begin
				coordCnt = 4'h4;
				derivCnt = iifd_pkg::DERIV_2D;
				dimArray = 1'b1;
			end
			iifd_pkg::DIM_3D, iifd_pkg::DIM_CUBE: begin
				coordCnt = 4'h3;
				derivCnt = iifd_pkg::DERIV_3D;
				dimArray = instr.dim == iifd_pkg::DIM_CUBE;
			end
			default: begin
				coordCnt = 4'h3;
				derivCnt = iifd_pkg::DERIV_2D;
				dimArray = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// address operand layout
	always_comb begin
		bodyCnt   = isResinfo ? 4'h1 : coordCnt + {3'h0, hasTrail}; // RQ22 RQ23
		bodyRegs  = halfRegs(bodyCnt, instr.halfWidthAddressBit); // RQ12
		derivRegs = hasDeriv ?
			halfRegs(derivCnt, instr.halfWidthAddressBit) : 4'h0; // RQ19
		pOfs      = instr.addrRegBase; // RQ22
		pBias     = pOfs + (hasOfs ? {4'h0, iifd_pkg::OFFSET_REGS} : 8'h00);
		pCmp      = pBias + (hasBias ? {4'h0, iifd_pkg::BIAS_REGS} : 8'h00);
		pDeriv    = pCmp + (hasCmp ? {4'h0, iifd_pkg::CMP_REGS} : 8'h00);
		pBody     = pDeriv + {4'h0, derivRegs};
	end

	// ==========================================================
	// data register layout per component
	always_comb begin
		maskCnt  = popCount(instr.componentMask);
		dataRegs = halfRegs(maskCnt, instr.halfWidthDataBit); // RQ13
	end

	for (genvar i = 0; i < iifd_pkg::MASK_W; i++) begin : gComp
		logic [iifd_pkg::CNT_W-1:0] pre;
		always_comb begin
			pre = '0;
			// half-data writes: position is a word count only
			if (instr.halfWidthDataBit & isSt) begin
				pre       = 4'(i); // RQ7
				compEn[i] = 4'(i) < maskCnt; // RQ7
			end else begin
				pre       = popCount(instr.componentMask &
					4'((1 << i) - 1)); // RQ5 RQ6
				compEn[i] = instr.componentMask[i]; // RQ5 RQ6
			end
			compReg[i*iifd_pkg::VREG_W +: iifd_pkg::VREG_W] =
				instr.dataRegBase +
				{4'h0, instr.halfWidthDataBit ? (pre >> 1) : pre};
			compHigh[i] = instr.halfWidthDataBit & pre[0]; // RQ7 RQ13
		end
	end

	// ==========================================================
	// request assembly
	always_comb begin
		nxt_req              = '0;
		nxt_req.samplerReg   = {instr.samplerSelector,
			iifd_pkg::SEL_LOW_ZERO}; // RQ1
		nxt_req.resourceReg  = {instr.resourceSelector,
			iifd_pkg::SEL_LOW_ZERO}; // RQ1
		nxt_req.resourceSpan = (dimArray | (instr.dim == iifd_pkg::DIM_3D)) ?
			iifd_pkg::RSRC_WIDE : iifd_pkg::RSRC_NARROW; // RQ1
		nxt_req.hasSampler   = isSmp;
		nxt_req.isLoad       = isLd;
		nxt_req.isStore      = isSt;
		nxt_req.isAtomic     = isAt;
		nxt_req.unnormalized = instr.unnormalizedCoordBit; // RQ3
		nxt_req.floatAddr    = isSmp; // RQ15
		nxt_req.faceMul      = isSmp ? iifd_pkg::FACE_MUL_FLOAT :
			iifd_pkg::FACE_MUL_UINT; // RQ15
		nxt_req.explicitLod  = lodMode == iifd_pkg::LODM_EXPL; // RQ17
		nxt_req.levelZero    = lodMode == iifd_pkg::LODM_ZERO; // RQ17
		nxt_req.lodClamp     = lodMode == iifd_pkg::LODM_CLAMP; // RQ18
		nxt_req.hasOffset    = hasOfs;
		nxt_req.hasBias      = hasBias;
		nxt_req.hasCompare   = hasCmp;
		nxt_req.offsetReg    = pOfs;
		nxt_req.biasReg      = pBias;
		nxt_req.compareReg   = pCmp;
		nxt_req.derivReg     = pDeriv;
		nxt_req.derivCount   = hasDeriv ? derivCnt : 4'h0;
		nxt_req.bodyReg      = pBody;
		nxt_req.bodyCount    = bodyCnt;
		nxt_req.addrRegCount = 4'(pBody - pOfs) + bodyRegs;
		nxt_req.halfAddr     = instr.halfWidthAddressBit; // RQ12
		nxt_req.halfData     = instr.halfWidthDataBit; // RQ13
		nxt_req.numberFormat = instr.numberFormatField; // RQ13
		nxt_req.compEnable   = compEn;
		nxt_req.compReg      = compReg;
		nxt_req.compHigh     = compHigh;
		nxt_req.dataRegCount = dataRegs;
		nxt_req.bypassL1     = isLd & instr.coherentBit; // RQ8
		nxt_req.writeThrough = isSt; // RQ8
		nxt_req.persistL1    = isSt & ~instr.coherentBit; // RQ8
		nxt_req.returnPrior  = isAt & instr.coherentBit; // RQ8
		nxt_req.missL2       = instr.systemCoherentBit; // RQ9
		nxt_req.nackAllowed  = isLd & instr.texelFailBit; // RQ10
		nxt_req.nackReg      = instr.dataRegBase + {4'h0, dataRegs}; // RQ10
		nxt_req.detailClampedAllowed = isLd & instr.lodWarningBit; // RQ11
		nxt_req.illegal      =
			(instr.halfWidthDataBit & ~halfOk) | // RQ14 RQ24
			((isSt | isAt) & ~instr.unnormalizedCoordBit) | // RQ3 RQ24
			(~isResinfo & (instr.arrayDeclaredBit != dimArray)); // RQ4 RQ24
	end

	// ==========================================================
	// output registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reqValid_ff <= 1'b0;
		end else begin
			reqValid_ff <= instValid;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			req_ff <= '0;
		end else if (instValid) begin
			req_ff <= nxt_req;
		end
	end

	// ==========================================================
	// checks
	selector_align_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ1
		instValid |=> req_ff.resourceReg[1:0] == 2'h0 &&
			req_ff.resourceReg[6:2] == $past(instr.resourceSelector))
		else $error("resource selector not aligned");
	store_unnorm_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ3
		instValid && instr.opcodeField == 7'h08 &&
			!instr.unnormalizedCoordBit |=> req_ff.illegal)
		else $error("store without unnormalized bit not flagged");
	write_slots_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ6
		instValid && instr.opcodeField == 7'h08 && !instr.halfWidthDataBit &&
			instr.componentMask == 4'h9 |=>
			req_ff.compEnable == 4'h9 &&
			req_ff.compReg[31:24] == req_ff.compReg[7:0] + 8'h01)
		else $error("mask 1001 write slots wrong");
	coherent_read_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ8
		reqValid_ff && req_ff.isLoad |-> req_ff.bypassL1 == $past(instr.coherentBit))
		else $error("coherent read bypass wrong");
	nack_slot_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ10
		reqValid_ff && req_ff.nackAllowed |->
			req_ff.nackReg == req_ff.compReg[7:0] + {4'h0, req_ff.dataRegCount} -
			(req_ff.compReg[7:0] - $past(instr.dataRegBase)))
		else $error("nack register misplaced");
	face_mul_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ15
		reqValid_ff |-> req_ff.faceMul == (req_ff.hasSampler ? 4'h8 : 4'h6))
		else $error("face multiplier wrong");
	bias_one_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ18
		reqValid_ff && req_ff.hasBias |->
			req_ff.compareReg == req_ff.biasReg + 8'h01)
		else $error("bias operand count wrong");
	offset_first_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ22
		reqValid_ff |->
			req_ff.biasReg == req_ff.offsetReg + {7'h00, req_ff.hasOffset})
		else $error("offset not first");
	half_op_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ14
		instValid && instr.halfWidthDataBit && instr.opcodeField == 7'h0e |=>
			req_ff.illegal)
		else $error("half data on resinfo not flagged");

endmodule // iifd_decoder

`default_nettype wire

// File: iifd_tex_addresser_model.sv
// texture addresser stand-in that takes decoded image requests
`timescale 1ns/1ps
`default_nettype none
module iifd_tex_addresser_model (
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	input  wire logic                reqValid,
	input  wire iifd_pkg::iifd_req_s req,
	output var  logic [15:0]         reqCount_ff,
	output var  iifd_pkg::iifd_req_s lastReq_ff
);
	// ==========================================================
	// request intake
	// every request is taken at once: the far side never stalls
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reqCount_ff <= 16'h0000;
			lastReq_ff  <= '0;
		end else if (reqValid) begin
			reqCount_ff <= reqCount_ff + 16'h0001;
			lastReq_ff  <= req;
		end
	end
endmodule // iifd_tex_addresser_model
`default_nettype wire

// File: iifd_decoder_tb.sv
// self-checking bench for the image instruction field decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module iifd_decoder_tb;
	logic                  ref_clk;
	logic                  rstn;
	logic                  instValid;
	iifd_pkg::iifd_instr_s instr;
	iifd_pkg::iifd_instr_s x;
	logic                  reqValid_ff;
	iifd_pkg::iifd_req_s   req_ff;
	iifd_pkg::iifd_req_s   got;
	logic [15:0]           reqCount;
	logic [15:0]           cnt0;
	iifd_pkg::iifd_req_s   lastReq;
	int                    n_fail;
	int                    check_count;
	logic [6:0]            halfOp [0:8] = '{iifd_pkg::OP_LOAD,
		iifd_pkg::OP_LOAD_MIP, iifd_pkg::OP_LOAD_PCK, iifd_pkg::OP_STORE_MIP,
		iifd_pkg::OP_RESINFO, 7'h40, 7'h60, 7'h67, iifd_pkg::OP_ATOMIC_LO};
	logic                  halfBad [0:8] = '{1'b0, 1'b0, 1'b1, 1'b0,
		1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

	iifd_decoder dut (
		.ref_clk    (ref_clk),
		.rstn       (rstn),
		.instValid  (instValid),
		.instr      (instr),
		.reqValid_ff(reqValid_ff),
		.req_ff     (req_ff)
	);
	iifd_tex_addresser_model model (
		.ref_clk    (ref_clk),
		.rstn       (rstn),
		.reqValid   (reqValid_ff),
		.req        (req_ff),
		.reqCount_ff(reqCount),
		.lastReq_ff (lastReq)
	);

	// ==========================================================
	// clock and watchdog
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		complete_run();
	end

	// ==========================================================
	// access tasks
	function automatic iifd_pkg::iifd_instr_s mk(input logic [6:0] op,
		input iifd_pkg::iifd_dim_e d);
		iifd_pkg::iifd_instr_s v;
		v = '0;
		v.opcodeField = op;
		v.addrRegBase = 8'h40;
		v.dataRegBase = 8'h20;
		v.dim = d;
		v.componentMask = 4'h1;
		v.unnormalizedCoordBit = 1'b1;
		return v;
	endfunction
	task automatic issue(input iifd_pkg::iifd_instr_s v);
		@(posedge ref_clk);
		instValid <= 1'b1;
		instr     <= v;
		@(posedge ref_clk);
		instValid <= 1'b0;
		#1;
		`CHK(reqValid_ff, 1'b1, "no answer")
		got = req_ff;
	endtask
	task automatic endTest(input string s);
		$display("test %s done", s);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// tests
	initial begin
		rstn = 1'b0;
		instValid = 1'b0;
		instr = '0;
		n_fail = 0;
		check_count = 0;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		#1;
		`CHK(reqValid_ff, 1'b0, "valid in reset")
		`CHK(req_ff, '0, "req in reset")
		endTest("reset");
		// store with mask 1001, then one cycle pulse
		x = mk(iifd_pkg::OP_STORE, iifd_pkg::DIM_2D);
		x.componentMask = 4'h9;
		issue(x);
		`CHK(got.compEnable, 4'h9, "store enable")
		`CHK(got.compReg[7:0], 8'h20, "red reg")
		`CHK(got.compReg[31:24], 8'h21, "alpha reg")
		`CHK(got.isStore, 1'b1, "store op")
		`CHK(got.unnormalized, 1'b1, "unnorm")
		`CHK(got.illegal, 1'b0, "legal store")
		@(posedge ref_clk);
		#1;
		`CHK(reqValid_ff, 1'b0, "pulse width")
		x.unnormalizedCoordBit = 1'b0;
		issue(x);
		`CHK(got.illegal, 1'b1, "store unnorm")
		x.opcodeField = iifd_pkg::OP_ATOMIC_HI;
		issue(x);
		`CHK(got.illegal, 1'b1, "atomic unnorm")
		endTest("store");
		// cache policy per op class
		for (int c = 0; c < 2; c++) begin
			x = mk(iifd_pkg::OP_LOAD, iifd_pkg::DIM_2D);
			x.coherentBit = c[0];
			issue(x);
			`CHK(got.bypassL1, c[0], "bypass")
			x.opcodeField = iifd_pkg::OP_STORE;
			issue(x);
			`CHK(got.persistL1, ~c[0], "persist")
			`CHK(got.writeThrough, 1'b1, "through")
			x.opcodeField = iifd_pkg::OP_ATOMIC_LO;
			issue(x);
			`CHK(got.returnPrior, c[0], "prior")
			`CHK(got.isAtomic, 1'b1, "atomic op")
		end
		endTest("cache");
		// load with system-coherent, texel-fail and lod-warning options, top sampler selector
		x = mk(iifd_pkg::OP_LOAD, iifd_pkg::DIM_3D);
		x.componentMask = 4'h7;
		x.systemCoherentBit = 1'b1;
		x.texelFailBit = 1'b1;
		x.lodWarningBit = 1'b1;
		x.samplerSelector = 5'h1f;
		x.resourceSelector = 5'h03;
		x.numberFormatField = 4'h5;
		issue(x);
		`CHK(got.samplerReg, 7'h7c, "sampler reg")
		`CHK(got.resourceReg, 7'h0c, "resource reg")
		`CHK(got.resourceSpan, 4'h8, "span")
		`CHK(got.dataRegCount, 4'h3, "data count")
		`CHK(got.compReg[15:8], 8'h21, "green reg")
		`CHK(got.missL2, 1'b1, "l2 miss")
		`CHK(got.nackAllowed, 1'b1, "nack")
		`CHK(got.nackReg, 8'h23, "nack reg")
		`CHK(got.detailClampedAllowed, 1'b1, "clamp warn")
		`CHK(got.numberFormat, 4'h5, "number format")
		`CHK(got.hasSampler, 1'b0, "no sampler")
		`CHK(got.faceMul, 4'h6, "face six")
		endTest("load");
		// half data: word count and opcode legality
		x = mk(iifd_pkg::OP_STORE, iifd_pkg::DIM_2D);
		x.componentMask = 4'ha;
		x.halfWidthDataBit = 1'b1;
		issue(x);
		`CHK(got.compEnable, 4'h3, "word count")
		`CHK(got.compHigh[1:0], 2'b10, "halves")
		`CHK(got.compReg[15:8], 8'h20, "word1 reg")
		`CHK(got.halfData, 1'b1, "half data")
		for (int i = 0; i < 9; i++) begin
			x.opcodeField = halfOp[i];
			issue(x);
			`CHK(got.illegal, halfBad[i], "half data op")
		end
		endTest("half data");
		// sampler address layouts
		x = mk(7'h4a, iifd_pkg::DIM_2D);
		issue(x);
		`CHK(got.offsetReg, 8'h40, "offset reg")
		`CHK(got.biasReg, 8'h41, "bias reg")
		`CHK(got.hasOffset, 1'b1, "has offset")
		`CHK(got.hasBias, 1'b1, "has bias")
		`CHK(got.bodyReg, 8'h42, "body reg")
		`CHK(got.bodyCount, 4'h2, "body count")
		`CHK(got.addrRegCount, 4'h4, "addr count")
		`CHK(got.floatAddr, 1'b1, "float addr")
		`CHK(got.faceMul, 4'h8, "face eight")
		x.opcodeField = 7'h54;
		x.dim = iifd_pkg::DIM_3D;
		issue(x);
		`CHK(got.compareReg, 8'h40, "cmp reg")
		`CHK(got.hasCompare, 1'b1, "has compare")
		`CHK(got.derivReg, 8'h41, "deriv reg")
		`CHK(got.derivCount, 4'h6, "deriv 3d")
		`CHK(got.bodyReg, 8'h47, "body after")
		`CHK(got.addrRegCount, 4'ha, "total")
		x.opcodeField = 7'h45;
		x.dim = iifd_pkg::DIM_1D;
		issue(x);
		`CHK(got.derivCount, 4'h2, "deriv 1d")
		x = mk(7'h41, iifd_pkg::DIM_2D);
		issue(x);
		`CHK(got.explicitLod, 1'b1, "explicit")
		`CHK(got.bodyCount, 4'h3, "lod last")
		x.opcodeField = 7'h43;
		issue(x);
		`CHK(got.levelZero, 1'b1, "level zero")
		x = mk(7'h46, iifd_pkg::DIM_CUBE);
		x.arrayDeclaredBit = 1'b1;
		issue(x);
		`CHK(got.lodClamp, 1'b1, "clamp")
		`CHK(got.bodyCount, 4'h4, "clamp last")
		x = mk(7'h58, iifd_pkg::DIM_2D);
		x.halfWidthAddressBit = 1'b1;
		issue(x);
		`CHK(got.halfAddr, 1'b1, "half addr")
		`CHK(got.compareReg, 8'h41, "cmp full")
		`CHK(got.addrRegCount, 4'h3, "packed")
		x = mk(7'h40, iifd_pkg::DIM_2D_ARRAY);
		issue(x);
		`CHK(got.illegal, 1'b1, "array missing")
		x.arrayDeclaredBit = 1'b1;
		issue(x);
		`CHK(got.bodyCount, 4'h3, "slice")
		endTest("layout");
		// back to back requests
		@(posedge ref_clk);
		#1;
		cnt0 = reqCount;
		@(posedge ref_clk);
		instValid <= 1'b1;
		instr     <= mk(iifd_pkg::OP_LOAD, iifd_pkg::DIM_1D);
		@(posedge ref_clk);
		instr     <= mk(iifd_pkg::OP_STORE, iifd_pkg::DIM_1D);
		#1;
		`CHK(req_ff.isLoad, 1'b1, "first")
		@(posedge ref_clk);
		instValid <= 1'b0;
		#1;
		`CHK(reqValid_ff, 1'b1, "second valid")
		`CHK(req_ff.isStore, 1'b1, "second")
		@(posedge ref_clk);
		#1;
		`CHK(reqValid_ff, 1'b0, "idle")
		`CHK(reqCount, cnt0 + 16'h0002, "count")
		`CHK(lastReq.isStore, 1'b1, "far side last")
		endTest("back to back");
		complete_run();
	end
endmodule // iifd_decoder_tb
`default_nettype wire
